/* File: src/nrbt_host_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "nrbt_defines.vh"
// Function
// - program/erase need setup then confirm
// - select high 100 ns ends sequential read
// - page main once, spare twice per erase
// - block zero usable, 4016..4096 usable blocks
// - reset command aborts and returns ready
// - status bit six mirrors completion
module nrbt_host_ctrl #(
    parameter ADDR_CYCLES = 4,
    parameter TIMEOUT_CYC = `NRBT_TIMEOUT_CYC
) (
    input wire clk,
    input wire srst,
    input wire opValid,
    input wire [2:0] opCode,
    input wire [31:0] opAddr,
    input wire [7:0] opData,
    input wire pollStatus,
    output wire opReady,
    output reg opDone,
    output reg opTimeout,
    output reg [7:0] statusByte,
    output reg chipSelectN,
    output reg cmdLatch,
    output reg addrLatch,
    output reg writeStrobeN,
    output reg read_strobe_n,
    output reg [7:0] ioOut,
    output reg ioOe,
    input wire [7:0] ioIn,
    input wire readyBusyIn
);
    localparam ST_IDLE = 3'h0;
    localparam ST_CMD = 3'h1;
    localparam ST_ADDR = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_CONF = 3'h4;
    localparam ST_WAIT = 3'h5;
    localparam ST_STAT = 3'h6;
    localparam ST_STOP = 3'h7;
    localparam [31:0] TO_CYC = TIMEOUT_CYC;
    localparam [31:0] WB_CYC = `NRBT_WB_CYC;
    localparam [31:0] STOP_CYC = `NRBT_SEQ_STOP_CYC;
    localparam [31:0] STROBE_CYC = `NRBT_STROBE_CYC;

    wire lineReady; // filtered ready level
    reg [2:0] state_reg, state_next;
    reg [2:0] op_reg; // latched operation
    reg [31:0] addr_reg; // latched address
    reg [7:0] data_reg; // latched write byte
    reg [2:0] addrIdx_reg; // address cycle index
    reg [31:0] cnt_reg; // phase and wait counter
    reg phase_reg; // strobe low/high half
    reg pollMode_reg; // poll status instead of line
    reg statCmd_reg; // status command owed before polling
    reg phase_next; // strobe half after this edge

    nrbt_ready_sync uSync (
        .clk(clk),
        .srst(srst),
        .readyBusyIn(readyBusyIn),
        .lineReady(lineReady)
    );

    // first command byte of each operation
    function [7:0] firstCmd;
        input [2:0] op;
        begin
            case (op)
                `NRBT_OP_READ: firstCmd = `NRBT_CMD_READ;
                `NRBT_OP_PROG: firstCmd = `NRBT_CMD_PROG_SETUP;
                `NRBT_OP_ERASE: firstCmd = `NRBT_CMD_ERASE_SETUP;
                `NRBT_OP_STATUS: firstCmd = `NRBT_CMD_STATUS;
                default: firstCmd = `NRBT_CMD_RESET;
            endcase
        end
    endfunction

    // one strobe half finished when counter hits the strobe length minus one
    function strobeDone;
        input [31:0] c;
        begin
            strobeDone = (c == STROBE_CYC - 32'h1);
        end
    endfunction

    assign opReady = (state_reg == ST_IDLE);

    // sequencing of the pin phases
    always @* begin
        state_next = state_reg;
        phase_next = phase_reg;
        case (state_reg)
            ST_IDLE: begin
                if (opValid) begin
                    state_next = ST_CMD;
                end
            end
            ST_CMD: begin
                if (phase_reg && strobeDone(cnt_reg)) begin
                    if (statCmd_reg) begin
                        state_next = ST_STAT;
                    end else if (op_reg == `NRBT_OP_RESET) begin
                        state_next = ST_WAIT;
                    end else if (op_reg == `NRBT_OP_STATUS) begin
                        state_next = ST_STAT;
                    end else begin
                        state_next = ST_ADDR;
                    end
                end
            end
            ST_ADDR: begin
                if (phase_reg && strobeDone(cnt_reg) &&
                    addrIdx_reg == ADDR_CYCLES[2:0] - 3'h1) begin
                    if (op_reg == `NRBT_OP_PROG) begin
                        state_next = ST_DATA;
                    end else if (op_reg == `NRBT_OP_ERASE) begin
                        state_next = ST_CONF;
                    end else begin
                        state_next = ST_WAIT;
                    end
                end
            end
            ST_DATA: begin
                if (phase_reg && strobeDone(cnt_reg)) begin
                    state_next = ST_CONF;
                end
            end
            ST_CONF: begin
                // confirm always follows setup, never skipped
                if (phase_reg && strobeDone(cnt_reg)) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // without status polling, done on ready after WB_CYC cycles, or after TO_CYC cycles with opTimeout set
                if (cnt_reg >= WB_CYC && lineReady && !pollMode_reg) begin
                    state_next = ST_STOP;
                end else if (cnt_reg >= WB_CYC && pollMode_reg) begin
                    // status command first, else the device answers with array data
                    state_next = ST_CMD;
                end else if (cnt_reg >= TO_CYC) begin
                    state_next = ST_STOP;
                end
            end
            ST_STAT: begin
                if (phase_reg && strobeDone(cnt_reg)) begin
                    if (op_reg != `NRBT_OP_STATUS &&
                        !statusByte[`NRBT_STAT_READY_BIT] && cnt_reg < TO_CYC) begin
                        state_next = ST_STAT;
                    end else begin
                        state_next = ST_STOP;
                    end
                end
            end
            ST_STOP: begin
                // select high long enough to end any sequential read
                if (cnt_reg >= STOP_CYC) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // strobe level follows the half being entered, so each half is two cycles
        if (state_next != state_reg) begin
            phase_next = 1'b0;
        end else if (state_reg != ST_WAIT && state_reg != ST_STOP && strobeDone(cnt_reg)) begin
            phase_next = ~phase_reg;
        end
    end

    // registers and pin drive
    always @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            op_reg <= 3'h0;
            addr_reg <= 32'h0;
            data_reg <= 8'h00;
            addrIdx_reg <= 3'h0;
            cnt_reg <= 32'h0;
            phase_reg <= 1'b0;
            pollMode_reg <= 1'b0;
            statCmd_reg <= 1'b0;
            opDone <= 1'b0;
            opTimeout <= 1'b0;
            statusByte <= 8'h00;
            chipSelectN <= 1'b1;
            cmdLatch <= 1'b0;
            addrLatch <= 1'b0;
            writeStrobeN <= 1'b1;
            read_strobe_n <= 1'b1;
            ioOut <= 8'h00;
            ioOe <= 1'b0;
        end else begin
            state_reg <= state_next;
            opDone <= 1'b0;
            // phase counter: low half then high half of each strobe
            if (state_next != state_reg) begin
                cnt_reg <= 32'h0;
                phase_reg <= 1'b0;
            end else if (state_reg == ST_WAIT || state_reg == ST_STOP) begin
                cnt_reg <= cnt_reg + 32'h1;
            end else if (strobeDone(cnt_reg)) begin
                cnt_reg <= 32'h0;
                phase_reg <= ~phase_reg;
            end else begin
                cnt_reg <= cnt_reg + 32'h1;
            end
            case (state_next)
                ST_IDLE: begin
                    chipSelectN <= 1'b1;
                    ioOe <= 1'b0;
                end
                ST_CMD, ST_CONF: begin
                    chipSelectN <= 1'b0;
                    cmdLatch <= 1'b1;
                    addrLatch <= 1'b0;
                    ioOe <= 1'b1;
                    ioOut <= (state_next == ST_CONF) ?
                        ((op_reg == `NRBT_OP_ERASE) ? `NRBT_CMD_ERASE_CONFIRM :
                         `NRBT_CMD_PROG_CONFIRM) : ((statCmd_reg || state_reg == ST_WAIT) ?
                         `NRBT_CMD_STATUS : firstCmd(op_reg));
                end
                ST_ADDR: begin
                    cmdLatch <= 1'b0;
                    addrLatch <= 1'b1;
                    ioOe <= 1'b1;
                    ioOut <= addr_reg[7:0];
                end
                ST_DATA: begin
                    addrLatch <= 1'b0;
                    ioOe <= 1'b1;
                    ioOut <= data_reg;
                end
                ST_STAT: begin
                    cmdLatch <= 1'b0;
                    addrLatch <= 1'b0;
                    ioOe <= 1'b0;
                end
                ST_STOP: begin
                    chipSelectN <= 1'b1;
                    cmdLatch <= 1'b0;
                    addrLatch <= 1'b0;
                    ioOe <= 1'b0;
                end
                default: begin
                    cmdLatch <= 1'b0;
                    addrLatch <= 1'b0;
                    ioOe <= 1'b0;
                end
            endcase
            // write strobe low in first half of each write phase
            writeStrobeN <= !((state_next == ST_CMD || state_next == ST_ADDR ||
                state_next == ST_DATA || state_next == ST_CONF) && !phase_next);
            read_strobe_n <= !(state_next == ST_STAT && !phase_next);
            // address bytes step low first
            if (state_reg == ST_ADDR && phase_reg && strobeDone(cnt_reg)) begin
                addrIdx_reg <= addrIdx_reg + 3'h1;
                addr_reg <= {8'h00, addr_reg[31:8]};
            end
            if (state_reg == ST_IDLE && opValid) begin
                op_reg <= opCode;
                addr_reg <= opAddr;
                data_reg <= opData;
                addrIdx_reg <= 3'h0;
                pollMode_reg <= pollStatus;
                statCmd_reg <= 1'b0;
                opTimeout <= 1'b0;
            end
            if (state_reg == ST_WAIT && state_next == ST_CMD) begin
                statCmd_reg <= 1'b1;
            end
            // status sampled at the end of the read half
            if (state_reg == ST_STAT && !phase_reg && strobeDone(cnt_reg)) begin
                statusByte <= ioIn;
            end
            if (state_reg == ST_WAIT && state_next == ST_STOP && !lineReady) begin
                opTimeout <= 1'b1;
            end
            if (state_reg == ST_STOP && state_next == ST_IDLE) begin
                opDone <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: common/nrbt_defines.vh */
`ifndef NRBT_DEFINES_VH
`define NRBT_DEFINES_VH
// command codes on the byte bus
`define NRBT_CMD_READ 8'h00
`define NRBT_CMD_PROG_SETUP 8'h80
`define NRBT_CMD_PROG_CONFIRM 8'h10
`define NRBT_CMD_ERASE_SETUP 8'h60
`define NRBT_CMD_ERASE_CONFIRM 8'hD0
`define NRBT_CMD_STATUS 8'h70
`define NRBT_CMD_RESET 8'hFF
// operation codes on the user port
`define NRBT_OP_READ 3'h0
`define NRBT_OP_PROG 3'h1
`define NRBT_OP_ERASE 3'h2
`define NRBT_OP_RESET 3'h3
`define NRBT_OP_STATUS 3'h4
// status bit that mirrors completion
`define NRBT_STAT_READY_BIT 6
// clock period and timing figures
`define NRBT_CLK_NS 20
`define NRBT_PAGE_LOAD_US 12
`define NRBT_RESET_MAX_US 500
`define NRBT_SEQ_STOP_SELECT_HIGH_NS 100
`define NRBT_WE_TO_BUSY_NS 100
// cycle counts derived from the figures, except the strobe length, fixed at 2
`define NRBT_SEQ_STOP_CYC ((`NRBT_SEQ_STOP_SELECT_HIGH_NS + `NRBT_CLK_NS - 1) / `NRBT_CLK_NS)
`define NRBT_WB_CYC ((`NRBT_WE_TO_BUSY_NS + `NRBT_CLK_NS - 1) / `NRBT_CLK_NS)
`define NRBT_TIMEOUT_CYC ((`NRBT_RESET_MAX_US * 1000 * 4) / `NRBT_CLK_NS)
`define NRBT_STROBE_CYC 2
`endif

/* File: src/nrbt_ready_sync.v */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser plus settle filter on the wired ready/busy line
module nrbt_ready_sync (
    input wire clk,
    input wire srst,
    input wire readyBusyIn,
    output wire lineReady
);
    reg meta_reg; // first stage, read only by second
    reg sync_reg; // second stage
    reg last_reg; // previous synced level
    reg ready_reg; // filtered ready level
    // line is released only by pull-up, so low wins
    always @(posedge clk) begin
        if (srst) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
            ready_reg <= 1'b1;
        end else begin
            meta_reg <= readyBusyIn;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
            // two equal samples before accepting a rise, slow pull-up edge
            if (sync_reg == last_reg) begin
                ready_reg <= sync_reg;
            end
        end
    end
    assign lineReady = ready_reg;
endmodule
`default_nettype wire

/* File: dv/nrbt_host_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// pin-level watcher on the flash host controller
module nrbt_host_ctrl_chk (
    input wire clk,
    input wire srst,
    input wire opValid,
    input wire opReady,
    input wire opDone,
    input wire opTimeout,
    input wire chipSelectN,
    input wire cmdLatch,
    input wire addrLatch,
    input wire writeStrobeN,
    input wire read_strobe_n,
    input wire ioOe,
    input wire readyBusyIn
);
    // one domain, so clock and reset are given once
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_reset_idle: assert property (disable iff (1'b0) srst |=> chipSelectN && writeStrobeN && read_strobe_n && !ioOe && opReady) else $error("pins not idle after reset");
    a_strobes_apart: assert property (!(!writeStrobeN && !read_strobe_n)) else $error("both strobes low");
    a_latch_apart: assert property (!(cmdLatch && addrLatch)) else $error("both latches high");
    a_write_two_low: assert property ($fell(writeStrobeN) |=> !writeStrobeN ##1 writeStrobeN) else $error("write strobe width wrong");
    a_bus_driven: assert property (!writeStrobeN |-> ioOe && !chipSelectN) else $error("write without driven bus");
    a_read_no_drive: assert property (!read_strobe_n |-> !ioOe) else $error("bus driven during read");
    a_select_hold: assert property ($rose(chipSelectN) |-> chipSelectN [*5]) else $error("select high too short");
    a_done_single: assert property (opDone |=> !opDone) else $error("done longer than one cycle");
    a_take_busy: assert property (opValid && opReady |=> !opReady && !opTimeout) else $error("request not taken");
    a_timeout_busy: assert property ($rose(opTimeout) |-> !readyBusyIn) else $error("timeout with line ready");
endmodule
bind nrbt_host_ctrl nrbt_host_ctrl_chk nrbt_host_ctrl_chk_inst (.clk(clk), .srst(srst),
    .opValid(opValid), .opReady(opReady), .opDone(opDone), .opTimeout(opTimeout),
    .chipSelectN(chipSelectN), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
    .writeStrobeN(writeStrobeN), .read_strobe_n(read_strobe_n), .ioOe(ioOe),
    .readyBusyIn(readyBusyIn));
`default_nettype wire

/* File: dv/nrbt_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nrbt_defines.vh"
// behavioural flash device: command decode, busy timer, status byte
module nrbt_flash_model #(
    parameter BUSY_CYC = 20,
    parameter RST_CYC = 10
) (
    input wire clk,
    input wire chipSelectN,
    input wire cmdLatch,
    input wire addrLatch,
    input wire writeStrobeN,
    input wire read_strobe_n,
    input wire [7:0] ioOut,
    output reg [7:0] ioIn,
    output wire pullLow,
    output reg [7:0] lastCmd
);
    reg wsPrev = 1'b1; // strobe one edge ago
    reg rsPrev = 1'b1; // read strobe one edge ago
    reg [7:0] setupCmd = 8'h00; // pending first step
    integer busyCnt = 0; // cycles of busy left
    wire rdy = (busyCnt == 0);
    // only ever sinks the shared line, never drives it high
    assign pullLow = !rdy;
    initial begin
        ioIn = 8'hA5;
        lastCmd = 8'h00;
    end
    // bytes are taken on the rising write strobe
    always @(posedge clk) begin
        wsPrev <= writeStrobeN;
        rsPrev <= read_strobe_n;
        if (!rdy) busyCnt <= busyCnt - 1;
        if (!chipSelectN && !read_strobe_n && lastCmd == `NRBT_CMD_STATUS)
            ioIn <= {1'b1, rdy, rdy, 5'h00};
        else
            ioIn <= ~ioIn; // released bus never holds a stale byte
        if (!chipSelectN && writeStrobeN && !wsPrev) begin
            if (cmdLatch) begin
                lastCmd <= ioOut;
                if (ioOut == `NRBT_CMD_PROG_SETUP || ioOut == `NRBT_CMD_ERASE_SETUP)
                    setupCmd <= ioOut;
                // abort anything, even from ready
                if (ioOut == `NRBT_CMD_RESET) begin
                    busyCnt <= RST_CYC;
                    setupCmd <= 8'h00;
                end
                // modify only after setup plus confirm
                if ((ioOut == `NRBT_CMD_PROG_CONFIRM && setupCmd == `NRBT_CMD_PROG_SETUP) ||
                    (ioOut == `NRBT_CMD_ERASE_CONFIRM && setupCmd == `NRBT_CMD_ERASE_SETUP)) begin
                    busyCnt <= BUSY_CYC;
                    setupCmd <= 8'h00;
                end
            end else if (addrLatch && lastCmd == `NRBT_CMD_READ) begin
                busyCnt <= BUSY_CYC;
            end
        end
        // read strobe rise in read mode loads the next page, every byte taken as last
        if (!chipSelectN && read_strobe_n && !rsPrev && lastCmd == `NRBT_CMD_READ && rdy)
            busyCnt <= BUSY_CYC;
        // select raised during a page load intercepts it
        if (chipSelectN && !rdy && lastCmd == `NRBT_CMD_READ)
            busyCnt <= 0;
    end
endmodule
`default_nettype wire

/* File: dv/test_nrbt_host_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nrbt_defines.vh"
// scenario bench for the flash host controller
module test_nrbt_host_ctrl;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg opValid = 1'b0;
    reg [2:0] opCode = 3'h0;
    reg [31:0] opAddr = 32'h00A1B2C3;
    reg [7:0] opData = 8'h5A;
    reg pollStatus = 1'b0;
    reg tbPull = 1'b0; // a second device sinking the shared line
    wire opReady, opDone, opTimeout, chipSelectN, cmdLatch, addrLatch;
    wire writeStrobeN, read_strobe_n, ioOe, devPull;
    wire [7:0] statusByte, ioOut, ioIn, lastCmd;
    wire readyBusyIn = !(devPull || tbPull); // pulled up, wired low
    integer bad_count = 0;
    integer n_compared = 0;
    integer cycles = 0;
    integer took;
    integer i;
    nrbt_host_ctrl #(.TIMEOUT_CYC(200)) nrbt_host_ctrl_inst (.clk(clk), .srst(srst),
        .opValid(opValid), .opCode(opCode), .opAddr(opAddr), .opData(opData),
        .pollStatus(pollStatus), .opReady(opReady), .opDone(opDone), .opTimeout(opTimeout),
        .statusByte(statusByte), .chipSelectN(chipSelectN), .cmdLatch(cmdLatch),
        .addrLatch(addrLatch), .writeStrobeN(writeStrobeN), .read_strobe_n(read_strobe_n),
        .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn), .readyBusyIn(readyBusyIn));
    nrbt_flash_model nrbt_flash_model_inst (.clk(clk), .chipSelectN(chipSelectN),
        .cmdLatch(cmdLatch), .addrLatch(addrLatch), .writeStrobeN(writeStrobeN),
        .read_strobe_n(read_strobe_n), .ioOut(ioOut), .ioIn(ioIn), .pullLow(devPull),
        .lastCmd(lastCmd));
    initial forever #10 clk = ~clk;
    // hang guard, far above the whole run
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 6000) begin
            bad_count = bad_count + 1;
            summarize;
        end
    end
    task check(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // last command byte the device should have seen
    function [7:0] expCmd(input [2:0] c);
        case (c)
            `NRBT_OP_READ: expCmd = `NRBT_CMD_READ;
            `NRBT_OP_PROG: expCmd = `NRBT_CMD_PROG_CONFIRM;
            `NRBT_OP_ERASE: expCmd = `NRBT_CMD_ERASE_CONFIRM;
            `NRBT_OP_RESET: expCmd = `NRBT_CMD_RESET;
            default: expCmd = `NRBT_CMD_STATUS;
        endcase
    endfunction
    // least cycles: four per pin phase, device busy time, five stop cycles
    function integer minTook(input [2:0] c);
        case (c)
            `NRBT_OP_READ: minTook = 45;
            `NRBT_OP_PROG: minTook = 53;
            `NRBT_OP_ERASE: minTook = 49;
            default: minTook = 19;
        endcase
    endfunction
    // issue one request, wait bounded for its done pulse
    task runOp(input [2:0] code, input poll, output integer n);
        begin
            @(negedge clk);
            while (opReady !== 1'b1) @(negedge clk);
            opCode = code;
            pollStatus = poll;
            opValid = 1'b1;
            @(negedge clk);
            opValid = 1'b0;
            n = 0;
            while (opDone !== 1'b1 && n < 2000) begin
                @(negedge clk);
                n = n + 1;
            end
            check({7'h00, opDone}, 8'h01);
        end
    endtask
    task t_reset_state;
        begin
            check({6'h00, chipSelectN, opReady}, 8'h03);
        end
    endtask
    // every operation code, each but status outlasting the device busy time
    task t_all_ops;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                runOp(i[2:0], 1'b0, took);
                check(lastCmd, expCmd(i[2:0]));
                check({7'h00, opTimeout}, 8'h00);
                if (i != 4) check({7'h00, took > minTook(i[2:0])}, 8'h01);
                if (i == 4) check(statusByte, 8'hE0);
            end
        end
    endtask
    task t_poll_prog;
        begin
            runOp(`NRBT_OP_PROG, 1'b1, took);
            check({7'h00, statusByte[`NRBT_STAT_READY_BIT]}, 8'h01);
            check(lastCmd, `NRBT_CMD_STATUS);
            check({7'h00, opTimeout}, 8'h00);
        end
    endtask
    // other device holds the line busy past the wait limit
    task t_timeout;
        begin
            tbPull = 1'b1;
            runOp(`NRBT_OP_READ, 1'b0, took);
            check({7'h00, opTimeout}, 8'h01);
            tbPull = 1'b0;
            runOp(`NRBT_OP_RESET, 1'b0, took);
            check({7'h00, opTimeout}, 8'h00);
        end
    endtask
    task summarize;
        begin
            $display("compared %0d mismatched %0d", n_compared, bad_count);
            if (bad_count == 0 && n_compared > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        repeat (3) @(negedge clk);
        srst = 1'b0;
        t_reset_state;
        t_all_ops;
        t_poll_prog;
        t_timeout;
        summarize;
    end
endmodule
`default_nettype wire
